//--- shared/sensor_defines.svh
// timing constants and field positions for the sensor serial port and sync logic
// assumes a system clock whose rate is given in MHz below
`ifndef SENSOR_DEFINES_SVH
`define SENSOR_DEFINES_SVH

`define CLK_MHZ 20
`define WORD_BITS 16
`define WORD_MSB 15
`define FIFO_WORDS 16
// times in ns, as printed
`define T_STALL_NS 9000
`define T_SYNC_TO_READY_NS 670000
`define T_INVALID_NS 210000
`define T_SAMPLE_PERIOD_NS 1220703
`define T_READY_PULSE_NS 1000
// least time rounds up, longest and typical times round down
`define CYC_UP(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define CYC_DN(ns) (((ns) * `CLK_MHZ) / 1000)
`define TIMER_BITS 16

`endif

//--- shared/sensor_pkg.sv
// types shared by the sensor serial port and sync logic
// assumes sensor_defines.svh is on the include path
package sensor_pkg;
   `include "sensor_defines.svh"

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

   typedef enum logic [1:0] {
      SY_IDLE = 2'b00,
      SY_WAIT = 2'b01,
      SY_INVALID = 2'b10,
      SY_READY = 2'b11
   } sync_state_t;
endpackage : sensor_pkg

//--- src/sensor_spi_sync_timing.sv
// serial slave port (mode 3, 16-bit words) and sample-sync / data-ready timing
// assumes the host drives sclk_i, cs_n_i and mosi_i; sclk_i is a clock of its own
// Functional notes
// - burst reads need no stall gap; words run back to back.
// - serial output bit changes on every falling serial clock edge.
// - serial input bit is captured on every rising serial clock edge.
// - aux pin serves as general I/O or as external sync clock input.
// - data ready comes 670 us after sync edge, after 210 us invalid window.
// - clock idles high, sample on second edge, 16-bit words, MSB first.
// - by default data ready pin pulses after each internal sample cycle.
`timescale 1ns/1ns

// ----------------------------------------
// word fifo
// ----------------------------------------
module word_fifo import sensor_pkg::*; #(
   parameter int WIDTH = `WORD_BITS,
   parameter int DEPTH = `FIFO_WORDS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) $error("word_fifo depth must be a power of two of at least 2");

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop, ready_reg, ready_next;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   // ready is registered so the top-level ready output comes straight from a flop
   assign in_ready_o = ready_reg;
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem[rd_reg];

   always_comb begin
      wr_next = wr_reg + AW'(push);
      rd_next = rd_reg + AW'(pop);
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      ready_next = (cnt_next != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
      end else if (ce_i) begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
      end
   end

   // storage has no reset: only written entries are ever read
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem[wr_reg] <= in_data_i;
      end
   end
endmodule : word_fifo

// ----------------------------------------
// top
// ----------------------------------------
module sensor_spi_sync_timing import sensor_pkg::*; #(
   parameter int SYNC_TO_READY_CYC = `CYC_DN(`T_SYNC_TO_READY_NS),
   parameter int INVALID_CYC = `CYC_DN(`T_INVALID_NS),
   parameter int SAMPLE_PERIOD_CYC = `CYC_DN(`T_SAMPLE_PERIOD_NS),
   parameter int READY_PULSE_CYC = `CYC_DN(`T_READY_PULSE_NS)
) (
   // system clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // serial link (host side)
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   // words to send, from sample logic
   input wire logic tx_valid_i,
   input wire logic [`WORD_MSB:0] tx_data_i,
   output logic tx_ready_o,
   // words received
   output logic rx_valid_o,
   output logic [`WORD_MSB:0] rx_data_o,
   // mode and status
   input wire logic burst_mode_i,
   output logic stall_violation_o,
   // aux pin: general I/O or sync clock
   input wire logic sync_mode_i,
   input wire logic aux_out_i,
   input wire logic aux_dir_out_i,
   input wire logic aux_pin_or_sync_clock_i,
   output pin_drive_t aux_drive_o,
   output logic aux_in_o,
   // data ready pin and invalid window
   output logic data_ready_pin_o,
   output logic data_invalid_o
);
   localparam int SHORTEST = READY_PULSE_CYC;
   if (SYNC_TO_READY_CYC <= INVALID_CYC || INVALID_CYC < 1 || SHORTEST < 1 || SAMPLE_PERIOD_CYC <= READY_PULSE_CYC
       || SAMPLE_PERIOD_CYC >= (1 << `TIMER_BITS)) $error("sensor_spi_sync_timing timing parameters out of range");
   localparam logic [`TIMER_BITS-1:0] STALL_CYC = `TIMER_BITS'(`CYC_UP(`T_STALL_NS));
   localparam logic [`TIMER_BITS-1:0] WAIT_CYC = `TIMER_BITS'(SYNC_TO_READY_CYC - INVALID_CYC);

   // ----------------------------------------
   // link domain: shift registers on the serial clock
   // ----------------------------------------
   // chip select high clears the link bit counters, shift registers and miso output asynchronously, so a frame always starts at bit zero
   logic link_rst_n;
   assign link_rst_n = rst_n_i && !cs_n_i;

   logic [`WORD_MSB:0] tx_hold_reg, tx_hold_next;
   logic [3:0] tx_cnt_reg, tx_cnt_next;
   logic [`WORD_MSB:0] tx_sh_reg, tx_sh_next;
   logic miso_reg, miso_next, tx_ack_reg, tx_ack_next;

   always_comb begin
      tx_cnt_next = tx_cnt_reg + 4'h1;
      tx_ack_next = tx_ack_reg;
      if (tx_cnt_reg == 4'h0) begin
         miso_next = tx_hold_reg[`WORD_MSB];
         tx_sh_next = {tx_hold_reg[`WORD_MSB-1:0], 1'b0};
         tx_ack_next = !tx_ack_reg;
      end else begin
         miso_next = tx_sh_reg[`WORD_MSB];
         tx_sh_next = {tx_sh_reg[`WORD_MSB-1:0], 1'b0};
      end
   end

   always_ff @(negedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_cnt_reg <= 4'h0;
         tx_sh_reg <= 16'h0000;
         miso_reg <= 1'b0;
         miso_oe_o <= 1'b0;
      end else begin
         tx_cnt_reg <= tx_cnt_next;
         tx_sh_reg <= tx_sh_next;
         miso_reg <= miso_next;
         miso_oe_o <= 1'b1;
      end
   end

   // the ack toggle must survive chip select so the system side sees every load
   always_ff @(negedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_ack_reg <= 1'b0;
      end else if (!cs_n_i) begin
         tx_ack_reg <= tx_ack_next;
      end
   end
   assign miso_o = miso_reg;

   logic [3:0] rx_cnt_reg, rx_cnt_next;
   logic [`WORD_MSB:0] rx_sh_reg, rx_sh_next, rx_word_reg, rx_word_next;
   logic rx_tgl_reg, rx_tgl_next;

   always_comb begin
      rx_cnt_next = rx_cnt_reg + 4'h1;
      rx_sh_next = {rx_sh_reg[`WORD_MSB-1:0], mosi_i};
      rx_word_next = rx_word_reg;
      rx_tgl_next = rx_tgl_reg;
      if (rx_cnt_reg == 4'(`WORD_MSB)) begin
         rx_word_next = rx_sh_next;
         rx_tgl_next = !rx_tgl_reg;
      end
   end

   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_cnt_reg <= 4'h0;
         rx_sh_reg <= 16'h0000;
      end else begin
         rx_cnt_reg <= rx_cnt_next;
         rx_sh_reg <= rx_sh_next;
      end
   end

   // finished word and its toggle outlive chip select, the system side reads them later
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_word_reg <= 16'h0000;
         rx_tgl_reg <= 1'b0;
      end else if (!cs_n_i) begin
         rx_word_reg <= rx_word_next;
         rx_tgl_reg <= rx_tgl_next;
      end
   end

   // ----------------------------------------
   // system domain: synchronisers
   // ----------------------------------------
   // bit 0 chip select, 1 rx toggle, 2 tx ack toggle, 3 aux pin
   logic [3:0] s1_reg, s2_reg, s3_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= 4'h1;
         s2_reg <= 4'h1;
         s3_reg <= 4'h1;
      end else if (ce_i) begin
         s1_reg <= {aux_pin_or_sync_clock_i, tx_ack_reg, rx_tgl_reg, cs_n_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // ----------------------------------------
   // transmit fifo and hold word
   // ----------------------------------------
   logic fifo_valid, fifo_pop;
   logic [`WORD_MSB:0] fifo_data;
   logic hold_full_reg, hold_full_next;

   word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_WORDS)) tx_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_valid_i(tx_valid_i),
      .in_data_i(tx_data_i),
      .in_ready_o(tx_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop)
   );

   // the hold word changes right after a load is acknowledged, or when it is empty; a word that arrives
   // while the hold is empty can race a load, so the host should read after data ready
   logic tx_ack_edge;
   assign tx_ack_edge = s2_reg[2] != s3_reg[2];
   assign fifo_pop = fifo_valid && (!hold_full_reg || tx_ack_edge);

   always_comb begin
      tx_hold_next = tx_hold_reg;
      hold_full_next = hold_full_reg;
      if (fifo_pop) begin
         tx_hold_next = fifo_data;
         hold_full_next = 1'b1;
      end else if (tx_ack_edge) begin
         tx_hold_next = 16'h0000;
         hold_full_next = 1'b0;
      end
   end

   // ----------------------------------------
   // receive hand-off and stall check
   // ----------------------------------------
   logic [`TIMER_BITS-1:0] gap_reg, gap_next;
   logic rx_valid_next, stall_next, word_seen_reg, word_seen_next;
   logic [`WORD_MSB:0] rx_data_next;

   always_comb begin
      rx_valid_next = s2_reg[1] != s3_reg[1];
      rx_data_next = rx_valid_next ? rx_word_reg : rx_data_o;
      word_seen_next = word_seen_reg || rx_valid_next;
      gap_next = gap_reg;
      stall_next = 1'b0;
      if (!s2_reg[0]) begin
         // select low: a fresh start after a short idle breaks the normal-mode gap
         if (s3_reg[0] && word_seen_reg && gap_reg < STALL_CYC && !burst_mode_i) begin
            stall_next = 1'b1;
         end
         gap_next = '0;
      end else if (gap_reg != STALL_CYC) begin
         gap_next = gap_reg + `TIMER_BITS'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_hold_reg <= 16'h0000;
         hold_full_reg <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 16'h0000;
         word_seen_reg <= 1'b0;
         gap_reg <= '0;
         stall_violation_o <= 1'b0;
      end else if (ce_i) begin
         tx_hold_reg <= tx_hold_next;
         hold_full_reg <= hold_full_next;
         rx_valid_o <= rx_valid_next;
         rx_data_o <= rx_data_next;
         word_seen_reg <= word_seen_next;
         gap_reg <= gap_next;
         stall_violation_o <= stall_next;
      end
   end

   // ----------------------------------------
   // aux pin and data-ready timing
   // ----------------------------------------
   sync_state_t st_reg, st_next;
   logic [`TIMER_BITS-1:0] tm_reg, tm_next;
   pin_drive_t aux_next;
   logic sync_edge;

   // rising sync edge; the host keeps the pulse wide enough to pass the synchroniser
   assign sync_edge = sync_mode_i && s2_reg[3] && !s3_reg[3];

   always_comb begin
      st_next = st_reg;
      tm_next = tm_reg + `TIMER_BITS'(1);
      aux_next.oe = !sync_mode_i && aux_dir_out_i;
      aux_next.out = aux_out_i;
      if (sync_edge) begin
         st_next = SY_WAIT;
         tm_next = '0;
      end else begin
         unique case (st_reg)
            SY_IDLE: begin
               if (sync_mode_i) begin
                  tm_next = '0;
               end else if (tm_reg == `TIMER_BITS'(SAMPLE_PERIOD_CYC - READY_PULSE_CYC - 1)) begin
                  st_next = SY_READY;
                  tm_next = '0;
               end
            end
            SY_WAIT: begin
               if (tm_reg == WAIT_CYC - `TIMER_BITS'(1)) begin
                  st_next = SY_INVALID;
                  tm_next = '0;
               end
            end
            SY_INVALID: begin
               if (tm_reg == `TIMER_BITS'(INVALID_CYC - 1)) begin
                  st_next = SY_READY;
                  tm_next = '0;
               end
            end
            SY_READY: begin
               if (tm_reg == `TIMER_BITS'(READY_PULSE_CYC - 1)) begin
                  st_next = SY_IDLE;
                  tm_next = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= SY_IDLE;
         tm_reg <= '0;
         aux_drive_o <= '0;
         aux_in_o <= 1'b0;
         data_ready_pin_o <= 1'b0;
         data_invalid_o <= 1'b0;
      end else if (ce_i) begin
         st_reg <= st_next;
         tm_reg <= tm_next;
         aux_drive_o <= aux_next;
         aux_in_o <= s2_reg[3];
         data_ready_pin_o <= (st_next == SY_READY);
         data_invalid_o <= (st_next == SY_INVALID);
      end
   end
endmodule : sensor_spi_sync_timing

//--- verification/sensor_timing_assertions.sv
// checker on the sensor port top-level ports
// assumes the bind below hands on the timing parameters
`timescale 1ns/1ns
module sensor_timing_assertions import sensor_pkg::*; #(
   parameter int SYNC_TO_READY_CYC = 60,
   parameter int INVALID_CYC = 20,
   parameter int SAMPLE_PERIOD_CYC = 100,
   parameter int READY_PULSE_CYC = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // watched ports
   input wire logic cs_n_i,
   input wire logic miso_oe_o,
   input wire logic burst_mode_i,
   input wire logic stall_violation_o,
   input wire logic sync_mode_i,
   input wire logic aux_out_i,
   input wire logic aux_dir_out_i,
   input wire logic aux_pin_or_sync_clock_i,
   input wire pin_drive_t aux_drive_o,
   input wire logic data_ready_pin_o,
   input wire logic data_invalid_o
);
   localparam int W_LO = SYNC_TO_READY_CYC - INVALID_CYC;
   localparam int W_HI = W_LO + 5;
   logic [15:0] inv_cnt_reg, inv_cnt_next, rdy_cnt_reg, rdy_cnt_next, per_cnt_reg, per_cnt_next;
   logic prev_reg, prev_next, armed_reg, armed_next, rise;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // period is only judged between two rises seen in internal mode
   always_comb begin
      rise = data_ready_pin_o & ~prev_reg;
      prev_next = data_ready_pin_o;
      armed_next = sync_mode_i ? 1'b0 : (armed_reg | rise);
      inv_cnt_next = data_invalid_o ? inv_cnt_reg + 16'h0001 : 16'h0000;
      rdy_cnt_next = data_ready_pin_o ? rdy_cnt_reg + 16'h0001 : 16'h0000;
      per_cnt_next = rise ? 16'h0001 : per_cnt_reg + 16'h0001;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {prev_reg, armed_reg, inv_cnt_reg, rdy_cnt_reg, per_cnt_reg} <= '0;
      end else if (ce_i) begin
         {prev_reg, armed_reg, inv_cnt_reg, rdy_cnt_reg, per_cnt_reg} <=
            {prev_next, armed_next, inv_cnt_next, rdy_cnt_next, per_cnt_next};
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_oe_deselect: assert property (cs_n_i |-> !miso_oe_o)
      else $error("miso enabled while deselected");
   a_stall_normal: assert property (stall_violation_o |-> !burst_mode_i)
      else $error("stall flagged in burst mode");
   a_stall_pulse: assert property (stall_violation_o |=> !stall_violation_o)
      else $error("stall flag longer than one cycle");
   a_aux_io_drive: assert property (!sync_mode_i && aux_dir_out_i |=>
      aux_drive_o.oe && aux_drive_o.out == $past(aux_out_i))
      else $error("aux pin not driven as asked");
   a_sync_no_drive: assert property (sync_mode_i |=> !aux_drive_o.oe)
      else $error("aux pin driven in sync mode");
   a_sync_to_invalid: assert property (sync_mode_i && $rose(aux_pin_or_sync_clock_i) |->
      ##[W_LO:W_HI] $rose(data_invalid_o))
      else $error("invalid window late or missing");
   a_invalid_len: assert property ($fell(data_invalid_o) |-> inv_cnt_reg == INVALID_CYC)
      else $error("invalid window length wrong");
   a_invalid_ready: assert property ($fell(data_invalid_o) |-> data_ready_pin_o)
      else $error("data ready not at end of invalid window");
   a_ready_width: assert property ($fell(data_ready_pin_o) |-> rdy_cnt_reg == READY_PULSE_CYC)
      else $error("data ready pulse width wrong");
   a_sample_period: assert property (rise && armed_reg && !sync_mode_i |-> per_cnt_reg == SAMPLE_PERIOD_CYC)
      else $error("internal sample period wrong");
   c_stall: cover property (stall_violation_o);
   c_invalid: cover property ($rose(data_invalid_o));
   c_ready: cover property (rise && armed_reg);
endmodule : sensor_timing_assertions
bind sensor_spi_sync_timing sensor_timing_assertions #(.SYNC_TO_READY_CYC(SYNC_TO_READY_CYC),
   .INVALID_CYC(INVALID_CYC), .SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC), .READY_PULSE_CYC(READY_PULSE_CYC)) chk (
   .clk_i, .rst_n_i, .ce_i, .cs_n_i, .miso_oe_o, .burst_mode_i, .stall_violation_o, .sync_mode_i, .aux_out_i,
   .aux_dir_out_i, .aux_pin_or_sync_clock_i, .aux_drive_o, .data_ready_pin_o, .data_invalid_o);

//--- verification/spi_host_model.sv
// host serial master model: clock idles high, 16-bit words, msb first
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ns
module spi_host_model (
   // serial link
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_i
);
   localparam int HALF = 3;
   logic oe_bad = 1'b0;
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic select();
      cs_n_o = 1'b0;
      #(HALF);
   endtask : select
   // released line shows the inverse so a stale bit cannot pass
   task automatic release_bus();
      #(HALF);
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask : release_bus
   task automatic xfer(input logic [15:0] d, output logic [15:0] q);
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         mosi_o = d[i];
         #(HALF);
         sclk_o = 1'b1;
         q[i] = miso_i;
         if (miso_oe_i !== 1'b1) oe_bad = 1'b1;
         #(HALF);
      end
   endtask : xfer
endmodule : spi_host_model

//--- verification/tb.sv
// bench: buffer fill and drain, frames, stall gap, aux pin, sync and data ready
// assumes the host model and the checker are compiled first
`timescale 1ns/1ns
module tb import sensor_pkg::*;;
   localparam int SYNC = 60;
   localparam int INV = 20;
   localparam int PER = 100;
   localparam int PULSE = 4;
   integer seed = 32'h7235;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   int stalls = 0;
   logic clk_i = 1'b0;
   logic ce = 1'b1;
   logic rst_n_i, sclk, cs_n, mosi, miso, miso_oe, tx_valid, tx_ready, rx_valid, burst, stall;
   logic sync_mode, aux_out, aux_dir, pin_drv, aux_in, rdy, inv;
   logic [15:0] tx_data, rx_data;
   logic [15:0] txq[$];
   pin_drive_t aux_drive;
   wire logic aux_pin = aux_drive.oe ? aux_drive.out : pin_drv;
   sensor_spi_sync_timing #(.SYNC_TO_READY_CYC(SYNC), .INVALID_CYC(INV), .SAMPLE_PERIOD_CYC(PER),
      .READY_PULSE_CYC(PULSE)) dut (
      .clk_i, .rst_n_i, .ce_i(ce), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_o(miso_oe), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .burst_mode_i(burst), .stall_violation_o(stall),
      .sync_mode_i(sync_mode), .aux_out_i(aux_out), .aux_dir_out_i(aux_dir),
      .aux_pin_or_sync_clock_i(aux_pin), .aux_drive_o(aux_drive), .aux_in_o(aux_in),
      .data_ready_pin_o(rdy), .data_invalid_o(inv));
   spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask : tick
   task automatic chk(input bit ok, input string msg);
      checks_done++;
      if (!ok) begin
         failures++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic frame(input logic [15:0] d, output logic [15:0] q);
      host.select();
      host.xfer(d, q);
      host.release_bus();
   endtask : frame
   task automatic until_rdy(input logic lvl, inout int t);
      int n = 0;
      while (rdy !== lvl && n < 300) begin
         tick(1);
         t++;
         n++;
      end
   endtask : until_rdy
   always @(posedge clk_i) begin
      cyc++;
      if (stall === 1'b1) stalls++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      logic [15:0] d, q, e;
      int t, ni;
      {rst_n_i, tx_valid, tx_data, burst, sync_mode, aux_out, aux_dir, pin_drv} = '0;
      repeat (3) @(posedge clk_i);
      #5 rst_n_i = 1'b1;
      tick(1);
      // fill until refused while the host stays idle
      repeat (24) begin
         tx_valid = 1'b1;
         tx_data = 16'($random(seed));
         // ready is settled here and decides the coming edge
         if (tx_ready === 1'b1) txq.push_back(tx_data);
         tick(1);
      end
      tx_valid = 1'b0;
      chk(txq.size() == 17 && tx_ready === 1'b0, "buffer fill count");
      // drain one word a frame, the last frame finds the buffer empty
      repeat (18) begin
         d = 16'($random(seed));
         e = (txq.size() > 0) ? txq.pop_front() : 16'h0000;
         frame(d, q);
         chk(q === e, "word sent");
         t = 0;
         while (rx_valid !== 1'b1 && t < 10) begin
            tick(1);
            t++;
         end
         chk(rx_data === d, "word received");
         tick(183);
      end
      chk(stalls == 0 && host.oe_bad === 1'b0, "spaced frames");
      frame(d, q);
      tick(176);
      frame(d, q);
      tick(6);
      chk(stalls == 1, "short gap flagged");
      burst = 1'b1;
      frame(d, q);
      tick(10);
      host.select();
      host.xfer(d, q);
      host.xfer(~d, q);
      host.release_bus();
      tick(8);
      chk(stalls == 1 && rx_data === ~d, "burst words");
      burst = 1'b0;
      repeat (8) begin
         aux_dir = 1'($random(seed));
         aux_out = 1'($random(seed));
         pin_drv = 1'($random(seed));
         tick(4);
         chk(aux_drive === {aux_out, aux_dir} && aux_in === aux_pin, "aux pin");
      end
      sync_mode = 1'b1;
      aux_dir = 1'b1;
      pin_drv = 1'b0;
      tick(PER);
      chk(aux_drive.oe === 1'b0, "sync pin is input");
      pin_drv = 1'b1;
      t = 0;
      ni = 0;
      while (rdy !== 1'b1 && t < 300) begin
         tick(1);
         t++;
         ni += (inv === 1'b1);
      end
      chk(t >= SYNC && t <= SYNC + 5 && ni == INV, "sync to ready");
      pin_drv = 1'b0;
      sync_mode = 1'b0;
      t = 0;
      until_rdy(1'b1, t);
      t = 0;
      until_rdy(1'b0, t);
      chk(t == PULSE, "ready width");
      until_rdy(1'b1, t);
      chk(t == PER, "sample period");
      // frozen cycles must not count towards the internal sample period
      t = 0;
      until_rdy(1'b0, t);
      ce = 1'b0;
      tick(10);
      ce = 1'b1;
      until_rdy(1'b1, t);
      chk(t == PER, "frozen period");
      test_done();
   end
endmodule : tb
